/* File: rtl/lintrx_channel.sv */
// lintrx_channel: enabling sequence, driver gate and wake filter per lane
// assumes mode already checked against the chip mode by the top
`timescale 1ns/100ps
`default_nettype none
module lintrx_channel (
    input  wire logic   sys_clk_i,
    input  wire logic   reset_n_i,
    lintrx_ch_if.ch     ch
);
    typedef struct packed {
        lintrx_pkg::lintrx_tx_state_t      st;
        logic [lintrx_pkg::LINTRX_CNT_W-1:0] en_cnt;
        logic [lintrx_pkg::LINTRX_CNT_W-1:0] wk_cnt;
        logic                              wk_long;
        logic                              woken;
        logic                              drv;
        logic                              rx;
    } lintrx_ch_state_t;

    lintrx_ch_state_t s_r;
    lintrx_ch_state_t s_nxt;

    // next state of the lane
    always_comb
    begin
        s_nxt = s_r;
        // enabling sequence; a fresh normal write restarts it
        if (ch.mode != lintrx_pkg::LINTRX_MODE_NORM)
        begin
            s_nxt.st     = lintrx_pkg::LINTRX_TX_IDLE;
            s_nxt.en_cnt = '0;
        end
        else
        begin
            case (s_r.st)
                lintrx_pkg::LINTRX_TX_IDLE:
                begin
                    s_nxt.st     = lintrx_pkg::LINTRX_TX_ENABLING;
                    s_nxt.en_cnt = '0;
                end
                lintrx_pkg::LINTRX_TX_ENABLING:
                begin
                    s_nxt.en_cnt = s_r.en_cnt + 1'b1;
                    if (!ch.tx_in)
                        s_nxt.st = lintrx_pkg::LINTRX_TX_BLOCKED;
                    else if (s_r.en_cnt == lintrx_pkg::LINTRX_CNT_W'(
                             lintrx_pkg::LINTRX_EN_CYC - 1))
                        s_nxt.st = lintrx_pkg::LINTRX_TX_LIVE;
                end
                lintrx_pkg::LINTRX_TX_BLOCKED:
                begin
                    // early dominant is swallowed until the interval is over and tx is high
                    if (s_r.en_cnt != lintrx_pkg::LINTRX_CNT_W'(
                        lintrx_pkg::LINTRX_EN_CYC))
                        s_nxt.en_cnt = s_r.en_cnt + 1'b1;
                    if (ch.tx_in && s_r.en_cnt ==
                        lintrx_pkg::LINTRX_CNT_W'(lintrx_pkg::LINTRX_EN_CYC))
                        s_nxt.st = lintrx_pkg::LINTRX_TX_LIVE;
                end
                lintrx_pkg::LINTRX_TX_LIVE: s_nxt.st = s_r.st;
                default: s_nxt.st = lintrx_pkg::LINTRX_TX_IDLE;
            endcase
            if (ch.mode_wr)
                s_nxt.st = lintrx_pkg::LINTRX_TX_IDLE;
        end
        // driver: only live normal mode, never receive-only
        s_nxt.drv = (s_nxt.st == lintrx_pkg::LINTRX_TX_LIVE)
                    && !ch.tx_in;

        // wake filter: long dominant ended by a rising edge
        s_nxt.wk_long = 1'b0;
        if (ch.mode != lintrx_pkg::LINTRX_MODE_WAKE || ch.rearm)
        begin
            s_nxt.wk_cnt = '0;
            // a wake that ends in the rearm cycle is kept, not lost
            s_nxt.woken  = (ch.mode == lintrx_pkg::LINTRX_MODE_WAKE)
                           && ch.bus_in && s_r.wk_long;
        end
        else if (!ch.bus_in)
        begin
            if (s_r.wk_cnt != lintrx_pkg::LINTRX_CNT_W'(
                lintrx_pkg::LINTRX_WAKE_CYC))
                s_nxt.wk_cnt = s_r.wk_cnt + 1'b1;
            s_nxt.wk_long = (s_r.wk_cnt == lintrx_pkg::LINTRX_CNT_W'(
                             lintrx_pkg::LINTRX_WAKE_CYC));
        end
        else
        begin
            if (s_r.wk_long)
                s_nxt.woken = 1'b1;
            s_nxt.wk_cnt = '0;
        end

        // receive output
        case (ch.mode)
            lintrx_pkg::LINTRX_MODE_NORM,
            lintrx_pkg::LINTRX_MODE_RXO: s_nxt.rx = ch.bus_in;
            lintrx_pkg::LINTRX_MODE_WAKE: s_nxt.rx = !s_nxt.woken;
            default: s_nxt.rx = 1'b1; // off: receiver idle, recessive
        endcase
    end

    // lane state register, off after reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_r.st      <= lintrx_pkg::LINTRX_TX_IDLE;
            s_r.en_cnt  <= '0;
            s_r.wk_cnt  <= '0;
            s_r.wk_long <= 1'b0;
            s_r.woken   <= 1'b0;
            s_r.drv     <= 1'b0;
            s_r.rx      <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign ch.drv_dom = s_r.drv;
    assign ch.rx_out  = s_r.rx;
    assign ch.woken   = s_r.woken;
endmodule : lintrx_channel
`default_nettype wire

/* File: rtl/lintrx_pkg.sv */
// lintrx_pkg: constants and types shared by the lin transceiver mode control
// assumes a single 10 MHz clock; no bus, plain ports only
package lintrx_pkg;
    // transceiver mode field encodings
    localparam logic [1:0] LINTRX_MODE_OFF  = 2'h0;
    localparam logic [1:0] LINTRX_MODE_WAKE = 2'h1;
    localparam logic [1:0] LINTRX_MODE_RXO  = 2'h2;
    localparam logic [1:0] LINTRX_MODE_NORM = 2'h3;
    localparam logic [1:0] LINTRX_MODE_RST  = LINTRX_MODE_OFF;

    // chip operating modes
    localparam logic [2:0] LINTRX_CHIP_NORMAL  = 3'h0;
    localparam logic [2:0] LINTRX_CHIP_STOP    = 3'h1;
    localparam logic [2:0] LINTRX_CHIP_SLEEP   = 3'h2;
    localparam logic [2:0] LINTRX_CHIP_RESTART = 3'h3;
    localparam logic [2:0] LINTRX_CHIP_FAILSAF = 3'h4;

    // timing, clock at 10 MHz
    localparam int LINTRX_CLK_HZ       = 10_000_000;
    localparam int LINTRX_EN_TIME_US   = 10;
    localparam int LINTRX_WAKE_FILT_US = 50;
    // least times in whole cycles; clock MHz rounds down
    localparam int LINTRX_EN_CYC =
        (LINTRX_EN_TIME_US * (LINTRX_CLK_HZ / 1_000_000));
    localparam int LINTRX_WAKE_CYC =
        (LINTRX_WAKE_FILT_US * (LINTRX_CLK_HZ / 1_000_000));
    localparam int LINTRX_CNT_W = 10;

    typedef enum logic [1:0] {
        LINTRX_TX_IDLE,
        LINTRX_TX_ENABLING,
        LINTRX_TX_BLOCKED,
        LINTRX_TX_LIVE
    } lintrx_tx_state_t;
endpackage : lintrx_pkg

/* File: rtl/lintrx_ch_if.sv */
// lintrx_ch_if: signals between the top and one channel datapath
// assumes channel index selection done by the top
`timescale 1ns/100ps
`default_nettype none
interface lintrx_ch_if;
    logic [1:0] mode;       // granted mode field
    logic       mode_wr;    // pulse: accepted mode write
    logic       tx_in;      // transmit input, low = dominant
    logic       bus_in;     // sampled bus level, low = dominant
    logic       drv_dom;    // pull bus dominant
    logic       rx_out;     // receive output
    logic       woken;      // wake latched
    logic       rearm;      // pulse: rearm wake detector
    modport top (output mode, mode_wr, tx_in, bus_in, rearm,
                 input drv_dom, rx_out, woken);
    modport ch  (input mode, mode_wr, tx_in, bus_in, rearm,
                 output drv_dom, rx_out, woken);
endinterface : lintrx_ch_if
`default_nettype wire

/* File: rtl/lintrx_top.sv */
// lintrx_top: mode field control for a set of lin transceivers
// assumes mode writes arrive as a one-cycle strobe from the control port
`timescale 1ns/100ps
`default_nettype none
module lintrx_top #(
    parameter int NUM_LIN = 4
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic [2:0]           chip_mode_i,
    input  wire logic                 mode_wr_i,
    input  wire logic [NUM_LIN-1:0]   mode_wr_sel_i,
    input  wire logic [1:0]           mode_wr_val_i,
    input  wire logic [NUM_LIN-1:0]   bus_tx_input_i,
    input  wire logic [NUM_LIN-1:0]   bus_level_i,
    output logic [NUM_LIN*2-1:0]      transceiver_mode_field_o,
    output logic [NUM_LIN-1:0]        bus_rx_output_o,
    output logic [NUM_LIN-1:0]        bus_drive_dom_o,
    output logic [NUM_LIN-1:0]        wake_event_o
);
    typedef struct packed {
        logic [NUM_LIN*2-1:0] field;
        logic [NUM_LIN-1:0]   wr;
        logic [2:0]           chip_prev;
        logic [NUM_LIN-1:0]   rearm;
    } lintrx_top_state_t;

    lintrx_top_state_t s_r;
    lintrx_top_state_t s_nxt;

    // mode is legal for the current chip mode
    function automatic logic lintrx_allowed(input logic [1:0] m,
                                            input logic [2:0] c);
        logic ok;
        ok = 1'b0;
        case (m)
            lintrx_pkg::LINTRX_MODE_OFF:  ok = 1'b1;
            lintrx_pkg::LINTRX_MODE_NORM:
                ok = (c == lintrx_pkg::LINTRX_CHIP_NORMAL);
            lintrx_pkg::LINTRX_MODE_RXO:
                ok = (c == lintrx_pkg::LINTRX_CHIP_NORMAL) ||
                     (c == lintrx_pkg::LINTRX_CHIP_STOP);
            lintrx_pkg::LINTRX_MODE_WAKE: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : lintrx_allowed

    // per-lane field update; disallowed writes leave the field alone
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wr = '0;
        s_nxt.chip_prev = chip_mode_i;
        for (int i = 0; i < NUM_LIN; i++)
        begin
            // entering stop, sleep or fail-safe rearms wake detection
            s_nxt.rearm[i] = (chip_mode_i != s_r.chip_prev) &&
                (chip_mode_i == lintrx_pkg::LINTRX_CHIP_STOP ||
                 chip_mode_i == lintrx_pkg::LINTRX_CHIP_SLEEP ||
                 chip_mode_i == lintrx_pkg::LINTRX_CHIP_FAILSAF);
            // a granted mode leaving its chip mode drops back to off
            if (!lintrx_allowed(s_r.field[i*2 +: 2], chip_mode_i))
                s_nxt.field[i*2 +: 2] = lintrx_pkg::LINTRX_MODE_OFF;
            // fail-safe entry forces wake-capable once, so off stays
            // selectable afterwards
            if (chip_mode_i != s_r.chip_prev &&
                chip_mode_i == lintrx_pkg::LINTRX_CHIP_FAILSAF)
                s_nxt.field[i*2 +: 2] = lintrx_pkg::LINTRX_MODE_WAKE;
            if (mode_wr_i && mode_wr_sel_i[i] &&
                lintrx_allowed(mode_wr_val_i, chip_mode_i))
            begin
                s_nxt.field[i*2 +: 2] = mode_wr_val_i;
                s_nxt.wr[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_r.field     <= {NUM_LIN{lintrx_pkg::LINTRX_MODE_RST}};
            s_r.wr        <= '0;
            s_r.chip_prev <= lintrx_pkg::LINTRX_CHIP_NORMAL;
            s_r.rearm     <= '0;
        end
        else
            s_r <= s_nxt;
    end

    // one datapath lane per transceiver
    genvar g;
    generate
        for (g = 0; g < NUM_LIN; g++)
        begin : g_lane
            lintrx_ch_if ch_if ();
            assign ch_if.mode    = s_r.field[g*2 +: 2];
            assign ch_if.mode_wr = s_r.wr[g];
            assign ch_if.rearm   = s_r.rearm[g] | s_r.wr[g];
            assign ch_if.tx_in   = bus_tx_input_i[g];
            assign ch_if.bus_in  = bus_level_i[g];
            lintrx_channel u_ch (
                .sys_clk_i (sys_clk_i),
                .reset_n_i (reset_n_i),
                .ch        (ch_if)
            );
            assign bus_rx_output_o[g] = ch_if.rx_out;
            assign bus_drive_dom_o[g] = ch_if.drv_dom;
            assign wake_event_o[g]    = ch_if.woken;
        end
    endgenerate

    assign transceiver_mode_field_o = s_r.field;
endmodule : lintrx_top
`default_nettype wire

/* File: dv/lintrx_sva.sv */
// lintrx_sva: port checker for lintrx_top, watching every lane
// assumes binding to lintrx_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module lintrx_sva #(
    parameter int NUM_LIN = 4
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic [2:0]           chip_mode_i,
    input  wire logic                 mode_wr_i,
    input  wire logic [NUM_LIN-1:0]   mode_wr_sel_i,
    input  wire logic [1:0]           mode_wr_val_i,
    input  wire logic [NUM_LIN-1:0]   bus_tx_input_i,
    input  wire logic [NUM_LIN-1:0]   bus_level_i,
    input  wire logic [NUM_LIN*2-1:0] transceiver_mode_field_o,
    input  wire logic [NUM_LIN-1:0]   bus_rx_output_o,
    input  wire logic [NUM_LIN-1:0]   bus_drive_dom_o,
    input  wire logic [NUM_LIN-1:0]   wake_event_o
);
    // earliest drive: write and field latency, then the whole interval
    localparam int         MIN_GAP = lintrx_pkg::LINTRX_EN_CYC + 2;
    localparam logic [1:0] M_OFF   = lintrx_pkg::LINTRX_MODE_OFF;
    localparam logic [1:0] M_WAKE  = lintrx_pkg::LINTRX_MODE_WAKE;
    localparam logic [1:0] M_RXO   = lintrx_pkg::LINTRX_MODE_RXO;
    localparam logic [1:0] M_NORM  = lintrx_pkg::LINTRX_MODE_NORM;
    localparam logic [2:0] C_NORM  = lintrx_pkg::LINTRX_CHIP_NORMAL;
    localparam logic [2:0] C_STOP  = lintrx_pkg::LINTRX_CHIP_STOP;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // every lane is watched: the scenarios spread over all of them
    genvar g;
    generate
        for (g = 0; g < NUM_LIN; g++)
        begin : g_lane
            logic [1:0] fl;
            logic       acc_norm;
            logic [9:0] en_cnt_r;
            logic [9:0] en_cnt_nxt;
            assign fl = transceiver_mode_field_o[g*2 +: 2];
            assign acc_norm = mode_wr_i && mode_wr_sel_i[g]
                && mode_wr_val_i == M_NORM && chip_mode_i == C_NORM;
            // cycles spent in normal since the last accepted normal write
            always_comb
            begin
                en_cnt_nxt = (&en_cnt_r) ? en_cnt_r : en_cnt_r + 10'h1;
                if (fl != M_NORM || acc_norm)
                    en_cnt_nxt = 10'h0;
            end
            always_ff @(posedge sys_clk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                    en_cnt_r <= 10'h0;
                else
                    en_cnt_r <= en_cnt_nxt;
            end
            AST_OFF_RX: assert property (
                (fl == M_OFF) [*2] |-> bus_rx_output_o[g])
                else $error("receive output low in off");
            AST_NORM_CHIP: assert property (
                fl == M_NORM |-> $past(chip_mode_i) == C_NORM)
                else $error("normal field outside chip normal");
            AST_RXO_CHIP: assert property (
                fl == M_RXO |-> $past(chip_mode_i) == C_NORM
                || $past(chip_mode_i) == C_STOP)
                else $error("receive-only outside normal or stop");
            AST_NO_EARLY: assert property (
                $rose(bus_drive_dom_o[g]) |-> en_cnt_r >= MIN_GAP)
                else $error("driver active inside enabling interval");
            AST_DRV_TX: assert property (
                $rose(bus_drive_dom_o[g]) |-> !$past(bus_tx_input_i[g]))
                else $error("dominant without low transmit input");
            AST_DRV_MODE: assert property (
                (fl != M_NORM) [*2] |-> !bus_drive_dom_o[g])
                else $error("driver active outside normal");
            AST_RX_BUS: assert property (
                (fl == M_RXO) [*2] ##0 !wake_event_o[g]
                |-> bus_rx_output_o[g] == $past(bus_level_i[g]))
                else $error("receive output not following bus");
            AST_WAKE_RX: assert property (
                wake_event_o[g] |-> !bus_rx_output_o[g])
                else $error("receive output high after wake");
            AST_WAKE_FIELD: assert property (
                wake_event_o[g] |-> $past(fl) == M_WAKE)
                else $error("wake shown with wrong field");
        end
    endgenerate
endmodule : lintrx_sva
`default_nettype wire

/* File: dv/lintrx_bus_model.sv */
// lintrx_bus_model: lin wires with pull-up and other nodes
// assumes active-high dominant requests from both ends
`timescale 1ns/100ps
`default_nettype none
module lintrx_bus_model #(
    parameter int NUM_LIN = 4
) (
    input  wire logic [NUM_LIN-1:0] drive_dom_i,
    input  wire logic [NUM_LIN-1:0] other_dom_i,
    output logic      [NUM_LIN-1:0] bus_level_o
);
    // wired-and: pull-up keeps a released wire recessive
    assign bus_level_o = ~(drive_dom_i | other_dom_i);
endmodule : lintrx_bus_model
`default_nettype wire

/* File: dv/lintrx_top_test.sv */
// lintrx_top_test: directed bench for the lin mode control
// assumes lintrx_top, the bus model and a 10 MHz clock
`timescale 1ns/100ps
`default_nettype none
module lintrx_top_test;
    logic       sys_clk;
    logic       reset_n;
    logic [2:0] chip;
    logic       wr;
    logic [3:0] sel;
    logic [1:0] val;
    logic [3:0] tx;
    logic [3:0] dom;
    logic [3:0] bus;
    logic [7:0] fld;
    logic [3:0] rx;
    logic [3:0] drv;
    logic [3:0] wk;
    int         num_errors;
    int         num_checks;
    lintrx_top #(.NUM_LIN(4)) DUT (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
        .chip_mode_i(chip), .mode_wr_i(wr), .mode_wr_sel_i(sel),
        .mode_wr_val_i(val), .bus_tx_input_i(tx), .bus_level_i(bus),
        .transceiver_mode_field_o(fld), .bus_rx_output_o(rx),
        .bus_drive_dom_o(drv), .wake_event_o(wk));
    lintrx_bus_model #(.NUM_LIN(4)) u_bus (.drive_dom_i(drv),
        .other_dom_i(dom), .bus_level_o(bus));
    // free-running system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // one-cycle strobe, then one cycle for the field to land
    task wr_mode(input int l, input logic [1:0] m);
        @(posedge sys_clk);
        wr <= 1'b1;
        sel <= 4'h1 << l;
        val <= m;
        @(posedge sys_clk);
        wr <= 1'b0;
        tick(1);
    endtask : wr_mode
    task t_normal;
        wr_mode(0, 2'h3);
        chk(fld[1:0], 2'h3);
        tick(105);
        chk(drv[0], 1'b0);
        @(posedge sys_clk) tx[0] <= 1'b0;
        tick(3);
        chk({drv[0], rx[0]}, 2'h2);
        @(posedge sys_clk) tx[0] <= 1'b1;
        tick(3);
        chk({drv[0], rx[0]}, 2'h1);
    endtask : t_normal
    // transmit pulled low early: must stay off the wire
    task t_early;
        wr_mode(1, 2'h3);
        @(posedge sys_clk) tx[1] <= 1'b0;
        tick(110);
        chk(drv[1], 1'b0);
        @(posedge sys_clk) tx[1] <= 1'b1;
        tick(3);
        @(posedge sys_clk) tx[1] <= 1'b0;
        tick(3);
        chk(drv[1], 1'b1);
        @(posedge sys_clk) tx <= 4'hf;
        tick(3);
    endtask : t_early
    task t_refuse;
        @(posedge sys_clk) chip <= lintrx_pkg::LINTRX_CHIP_STOP;
        wr_mode(2, 2'h3);
        chk(fld, 8'h00);
        wr_mode(2, 2'h2);
        chk(fld[5:4], 2'h2);
        @(posedge sys_clk)
        begin
            tx[2]  <= 1'b0;
            dom[2] <= 1'b1;
        end
        tick(3);
        chk({drv[2], rx[2]}, 2'h0);
        @(posedge sys_clk)
        begin
            tx[2]  <= 1'b1;
            dom[2] <= 1'b0;
        end
        @(posedge sys_clk) chip <= lintrx_pkg::LINTRX_CHIP_SLEEP;
        wr_mode(3, 2'h2);
        chk(fld[7:6], 2'h0);
    endtask : t_refuse
    task t_off;
        // every chip mode, fail-safe last; entering it forces wake-capable
        for (int c = 0; c < 5; c++)
        begin
            @(posedge sys_clk) chip <= 3'(c);
            wr_mode(3, 2'h1);
            chk(fld[7:6], 2'h1);
            wr_mode(3, 2'h0);
            chk(fld[7:6], 2'h0);
        end
        chk(fld[5:0], 6'h15);
    endtask : t_off
    // long dominant, then release: wakes only when wake-capable
    task dom_pulse;
        @(posedge sys_clk) dom[3] <= 1'b1;
        tick(lintrx_pkg::LINTRX_WAKE_CYC + 20);
        @(posedge sys_clk) dom[3] <= 1'b0;
        tick(4);
    endtask : dom_pulse
    task t_wake;
        @(posedge sys_clk) chip <= lintrx_pkg::LINTRX_CHIP_NORMAL;
        wr_mode(3, 2'h1);
        chk(fld[7:6], 2'h1);
        dom_pulse();
        chk({wk[3], rx[3]}, 2'h2);
        chk(fld[7:6], 2'h1);
        tick(20);
        chk(rx[3], 1'b0);
        wr_mode(3, 2'h0);
        tick(1);
        chk({wk[3], rx[3]}, 2'h1);
        dom_pulse();
        chk({wk[3], rx[3]}, 2'h1);
    endtask : t_wake
    task complete_run;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    // cuts a hang short; the sequence needs about 1400 cycles
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        num_errors++;
        complete_run();
    end
    initial
    begin
        {reset_n, chip, wr, sel, val, dom, num_errors, num_checks} = '0;
        tx = 4'hf;
        tick(5);
        chk({fld, rx, drv, wk}, 20'h00f00);
        @(posedge sys_clk) reset_n <= 1'b1;
        tick(1);
        t_normal();
        t_early();
        t_refuse();
        t_off();
        t_wake();
        complete_run();
    end
endmodule : lintrx_top_test
bind lintrx_top lintrx_sva #(.NUM_LIN(NUM_LIN)) u_sva (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .chip_mode_i(chip_mode_i), .mode_wr_i(mode_wr_i),
    .mode_wr_sel_i(mode_wr_sel_i), .mode_wr_val_i(mode_wr_val_i),
    .bus_tx_input_i(bus_tx_input_i), .bus_level_i(bus_level_i),
    .transceiver_mode_field_o(transceiver_mode_field_o),
    .bus_rx_output_o(bus_rx_output_o), .bus_drive_dom_o(bus_drive_dom_o),
    .wake_event_o(wake_event_o));
`default_nettype wire
